// ===== logic/emf_framer.sv
// Escaped message framer and deframer with CRC over unescaped bytes
//
// Contract
// - A framed message starts with an ampersand and ends with a percent sign.
// - After the percent sign all bytes are dropped until the next ampersand.
// - A body ampersand is sent as backslash then at-sign, and restored.
// - A body percent is sent as backslash then question mark, and restored.
// - A body backslash is sent doubled, and a pair collapses to one.
// - The transmit CRC covers the bytes before escaping.
// - The receive CRC is checked over the bytes after unescaping.
// - Raw reader commands pass with no markers and no escaping.
`timescale 1ns/100ps
`include "emf_defs.svh"
module emf_framer
  import emf_pkg::*;
#(
  parameter int CRC_W = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Transmit message side, unescaped bytes
  input  wire logic             txValid,
  input  wire logic [7:0]       txData,
  input  wire logic             txLast,
  input  wire logic             txRaw,
  output logic                  txReady,
  // Transmit line side
  output logic                  lineTxValid,
  output logic [7:0]            lineTxData,
  input  wire logic             lineTxReady,
  // Receive line side
  input  wire logic             lineRxValid,
  input  wire logic [7:0]       lineRxData,
  // Receive message side, unescaped bytes including trailing CRC
  output logic                  rxValid,
  output logic [7:0]            rxData,
  output logic                  rxEnd,
  output logic                  rxGood,
  output logic                  rxCrcError
);
  // Only the 16-bit residue check is built
  if (CRC_W != 16) begin : gBadCrcWidth
    $error("emf_framer supports CRC_W of 16 only");
  end

  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) r = {r[14:0], 1'b0} ^ `EMF_CRC_POLY;
      else r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : crcStep

  function automatic logic needsEsc(input logic [7:0] d);
    return d == `EMF_CHAR_OPEN || d == `EMF_CHAR_CLOSE || d == `EMF_CHAR_ESC;
  endfunction : needsEsc

  function automatic logic [7:0] escCode(input logic [7:0] d);
    if (d == `EMF_CHAR_OPEN) return `EMF_CHAR_AMP_SUB;
    if (d == `EMF_CHAR_CLOSE) return `EMF_CHAR_PCT_SUB;
    return `EMF_CHAR_ESC;
  endfunction : escCode

  logic rstMeta;
  logic rstSync;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ---------------- Transmit ----------------
  emf_tx_state_type txState;
  logic [15:0]      txCrc;
  logic [7:0]       txHold;
  logic             crcIdx;
  logic             crcEsc;
  // Set once the low CRC byte has gone, so an escape then leads to close
  logic             crcDone;
  logic [7:0]       crcByte;

  assign crcByte = crcIdx ? txCrc[7:0] : txCrc[15:8];
  // Message bytes are only taken when the line can take their first byte
  assign txReady = lineTxReady &&
                   (txState == TX_BODY || txState == TX_RAW);

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      txState     <= TX_IDLE;
      txCrc       <= `EMF_CRC_INIT;
      txHold      <= 8'h00;
      crcIdx      <= 1'b0;
      crcEsc      <= 1'b0;
      crcDone     <= 1'b0;
      lineTxValid <= 1'b0;
      lineTxData  <= 8'h00;
    end else begin
      if (lineTxValid && lineTxReady) lineTxValid <= 1'b0;
      case (txState)
        TX_IDLE: begin
          if (txValid && !lineTxValid) begin
            txCrc <= `EMF_CRC_INIT;
            if (txRaw) txState <= TX_RAW;
            else txState <= TX_OPEN;
          end
        end
        TX_OPEN: begin
          if (!lineTxValid || lineTxReady) begin
            lineTxValid <= 1'b1;
            lineTxData  <= `EMF_CHAR_OPEN;
            txState     <= TX_BODY;
          end
        end
        TX_BODY: begin
          if (txValid && lineTxReady) begin
            lineTxValid <= 1'b1;
            txCrc       <= crcStep(txCrc, txData);
            if (needsEsc(txData)) begin
              lineTxData <= `EMF_CHAR_ESC;
              txHold     <= escCode(txData);
              txState    <= TX_ESC2;
            end else begin
              lineTxData <= txData;
              if (txLast) txState <= TX_CRC;
            end
            crcEsc  <= txLast;
            crcIdx  <= 1'b0;
            crcDone <= 1'b0;
          end
        end
        TX_ESC2: begin
          if (lineTxReady) begin
            lineTxValid <= 1'b1;
            lineTxData  <= txHold;
            if (crcDone) begin
              txState <= TX_CLOSE;
            end else if (crcEsc) begin
              txState <= TX_CRC;
            end else begin
              txState <= TX_BODY;
            end
          end
        end
        TX_CRC: begin
          // CRC bytes travel inside the frame and so are escaped too
          if (lineTxReady) begin
            lineTxValid <= 1'b1;
            crcIdx      <= 1'b1;
            crcEsc      <= 1'b1;
            crcDone     <= crcIdx;
            if (needsEsc(crcByte)) begin
              lineTxData <= `EMF_CHAR_ESC;
              txHold     <= escCode(crcByte);
              txState    <= TX_ESC2;
            end else begin
              lineTxData <= crcByte;
              if (crcIdx) txState <= TX_CLOSE;
            end
          end
        end
        TX_CLOSE: begin
          if (lineTxReady) begin
            lineTxValid <= 1'b1;
            lineTxData  <= `EMF_CHAR_CLOSE;
            txState     <= TX_IDLE;
          end
        end
        TX_RAW: begin
          if (txValid && lineTxReady) begin
            lineTxValid <= 1'b1;
            lineTxData  <= txData;
            if (txLast) txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // ---------------- Receive ----------------
  emf_rx_state_type rxState;
  logic [15:0]      rxCrc;
  logic             rxOut;
  logic [7:0]       rxByte;

  // Restored byte for this cycle, computed once for both uses below
  always_comb begin
    rxOut  = 1'b0;
    rxByte = lineRxData;
    if (lineRxValid) begin
      if (rxState == RX_BODY && lineRxData != `EMF_CHAR_ESC &&
          lineRxData != `EMF_CHAR_CLOSE && lineRxData != `EMF_CHAR_OPEN) begin
        rxOut = 1'b1;
      end else if (rxState == RX_ESC) begin
        rxOut = 1'b1;
        if (lineRxData == `EMF_CHAR_AMP_SUB) rxByte = `EMF_CHAR_OPEN;
        else if (lineRxData == `EMF_CHAR_PCT_SUB) begin
          rxByte = `EMF_CHAR_CLOSE;
        end else if (lineRxData == `EMF_CHAR_ESC) begin
          rxByte = `EMF_CHAR_ESC;
        end else rxOut = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      rxState    <= RX_HUNT;
      rxCrc      <= `EMF_CRC_INIT;
      rxValid    <= 1'b0;
      rxData     <= 8'h00;
      rxEnd      <= 1'b0;
      rxGood     <= 1'b0;
      rxCrcError <= 1'b0;
    end else begin
      rxValid    <= rxOut;
      rxData     <= rxByte;
      rxEnd      <= 1'b0;
      rxGood     <= 1'b0;
      rxCrcError <= 1'b0;
      if (rxOut) rxCrc <= crcStep(rxCrc, rxByte);
      if (lineRxValid) begin
        if (lineRxData == `EMF_CHAR_OPEN) begin
          // A fresh opener restarts collection even mid-frame
          rxState <= RX_BODY;
          rxCrc   <= `EMF_CRC_INIT;
        end else begin
          case (rxState)
            RX_HUNT: rxState <= RX_HUNT;
            RX_BODY: begin
              if (lineRxData == `EMF_CHAR_ESC) rxState <= RX_ESC;
              else if (lineRxData == `EMF_CHAR_CLOSE) begin
                rxState    <= RX_HUNT;
                rxEnd      <= 1'b1;
                // Running CRC over data plus its CRC leaves zero residue
                rxGood     <= rxCrc == 16'h0000;
                rxCrcError <= rxCrc != 16'h0000;
              end
            end
            RX_ESC: begin
              if (rxOut) rxState <= RX_BODY;
              else rxState <= RX_HUNT;
            end
            default: rxState <= RX_HUNT;
          endcase
        end
      end
    end
  end
endmodule : emf_framer

// ===== logic/emf_defs.svh
// Character codes and CRC settings for the message framer
`ifndef EMF_DEFS_SVH
`define EMF_DEFS_SVH
`define EMF_CHAR_OPEN   8'h26
`define EMF_CHAR_CLOSE  8'h25
`define EMF_CHAR_ESC    8'h5c
`define EMF_CHAR_AMP_SUB 8'h40
`define EMF_CHAR_PCT_SUB 8'h3f
`define EMF_CRC_POLY    16'h1021
`define EMF_CRC_INIT    16'hffff
`endif

// ===== logic/emf_pkg.sv
// Types shared by the message framer
package emf_pkg;
  typedef enum logic [2:0] {
    TX_IDLE, TX_OPEN, TX_BODY, TX_ESC2, TX_CRC, TX_CLOSE, TX_RAW
  } emf_tx_state_type;
  typedef enum logic [1:0] {
    RX_HUNT, RX_BODY, RX_ESC
  } emf_rx_state_type;
endpackage : emf_pkg

// ===== test/emf_framer_props.sv
// Port checker for the message framer
`timescale 1ns/100ps
module emf_framer_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Line and message sides
  input wire logic       lineTxValid,
  input wire logic [7:0] lineTxData,
  input wire logic       lineTxReady,
  input wire logic       lineRxValid,
  input wire logic [7:0] lineRxData,
  input wire logic       rxValid,
  input wire logic [7:0] rxData,
  input wire logic       rxEnd,
  input wire logic       rxGood,
  input wire logic       rxCrcError
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence stall; lineTxValid && !lineTxReady; endsequence
  sequence held; lineTxValid && $stable(lineTxData); endsequence
  sequence out(b); rxValid && rxData == b; endsequence
  hold_byte_a: assert property (stall |=> held)
    else $error("line byte lost in stall");
  amp_esc_a: assert property (out(8'h26) |-> $past(lineRxData) == 8'h40)
    else $error("ampersand not from escape");
  pct_esc_a: assert property (out(8'h25) |-> $past(lineRxData) == 8'h3f)
    else $error("percent not from escape");
  bsl_esc_a: assert property (out(8'h5c) |-> $past(lineRxData) == 8'h5c)
    else $error("backslash not from pair");
  rx_cause_a: assert property (rxValid |-> $past(lineRxValid))
    else $error("byte out with no line byte");
  end_cause_a: assert property (rxEnd |-> $past(lineRxData) == 8'h25)
    else $error("end without close");
  flag_end_a: assert property (rxGood || rxCrcError |-> rxEnd)
    else $error("verdict without end");
  one_verdict_a: assert property (rxEnd |-> rxGood ^ rxCrcError)
    else $error("end needs one verdict");
endmodule : emf_framer_props
bind emf_framer emf_framer_props props (.sys_clk, .rst_n, .lineTxValid,
  .lineTxData, .lineTxReady, .lineRxValid, .lineRxData, .rxValid, .rxData,
  .rxEnd, .rxGood, .rxCrcError);

// ===== test/emf_host.sv
// Host-side line sink with random stalls
`timescale 1ns/100ps
module emf_host (
  // Clock
  input  wire logic       sys_clk,
  // Line from the framer
  input  wire logic       lineTxValid,
  input  wire logic [7:0] lineTxData,
  output logic            lineTxReady
);
  byte unsigned got[$];
  int           seed = 39278;
  initial lineTxReady = 0;
  // Stalls prove each line byte is held
  always @(posedge sys_clk) begin
    if (lineTxValid === 1'b1 && lineTxReady === 1'b1) begin
      got.push_back(lineTxData);
    end
    lineTxReady <= #1 ($random(seed) % 4) != 0;
  end
endmodule : emf_host

// ===== test/emf_framer_bench.sv
// Self-checking bench for the message framer
`timescale 1ns/100ps
`include "emf_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module emf_framer_bench;
  logic        sys_clk = 0, rst_n = 0, txValid = 0, txLast = 0, txRaw = 0;
  logic        lineRxValid = 0, txReady, lineTxValid, lineTxReady, rxValid;
  logic        rxEnd, rxGood, rxCrcError, endGood, endErr;
  logic [7:0]  txData = 0, lineRxData = 0, lineTxData, rxData;
  logic [15:0] crc;
  logic [31:0] r;
  int          n_errors = 0, total_checks = 0, seed = 39278, cyc, nEnd, m;
  byte unsigned msg[$], exp[$], got[$];
  emf_framer dut (.sys_clk, .rst_n, .txValid, .txData, .txLast, .txRaw,
    .txReady, .lineTxValid, .lineTxData, .lineTxReady, .lineRxValid,
    .lineRxData, .rxValid, .rxData, .rxEnd, .rxGood, .rxCrcError);
  emf_host host (.sys_clk, .lineTxValid, .lineTxData, .lineTxReady);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    cyc++;
    if (rxValid === 1'b1) got.push_back(rxData);
    if (rxEnd === 1'b1) begin
      nEnd++;
      endGood = rxGood;
      endErr = rxCrcError;
    end
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  function automatic logic [15:0] crc16();
    logic [15:0] c;
    c = `EMF_CRC_INIT;
    foreach (msg[i]) for (int b = 7; b >= 0; b--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ msg[i][b]) ? `EMF_CRC_POLY : 16'h0);
    return c;
  endfunction : crc16
  function automatic void addx(byte unsigned b);
    if (b inside {8'h26, 8'h25, 8'h5c}) begin
      exp.push_back(8'h5c);
      exp.push_back(b == 8'h26 ? 8'h40 :
                    b == 8'h25 ? 8'h3f : 8'h5c);
    end else
      exp.push_back(b);
  endfunction : addx
  task automatic lbyte(byte unsigned b);
    lineRxValid = 1;
    lineRxData = b;
    @(posedge sys_clk);
    #1;
  endtask : lbyte
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1;
    repeat (3) @(posedge sys_clk);
    #1;
    for (int k = 0; k < 12; k++) begin
      m = k % 4;
      msg.delete();
      repeat (2 + k % 5) begin
        r = $random(seed);
        msg.push_back(r[1:0] == 0 ? 8'h26 : r[1:0] == 1 ? 8'h25 :
                      r[1:0] == 2 ? 8'h5c : r[15:8]);
      end
      crc = crc16() ^ {7'h0, m == 3, 8'h0};
      exp = {8'h26};
      foreach (msg[i]) addx(msg[i]);
      addx(crc[15:8]);
      addx(crc[7:0]);
      exp.push_back(8'h25);
      host.got.delete();
      got.delete();
      nEnd = 0;
      if (m == 1) exp = msg;
      if (m < 2) begin
        foreach (msg[i]) begin
          txValid = 1;
          txRaw = m[0];
          txData = msg[i];
          txLast = i == msg.size() - 1;
          do @(posedge sys_clk); while (txReady !== 1'b1);
          #1;
        end
        txValid = 0;
        for (int w = 0; w < 300 && host.got.size() < exp.size(); w++)
          @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        #1;
      end else begin
        // A frame cut by a bad escape and stray bytes must leave no trace
        exp = {8'h26, 8'h5c, 8'h41, 8'h25, 8'h5c, 8'h41, exp,
               8'h41, 8'h5c};
        foreach (exp[i]) lbyte(exp[i]);
        lineRxValid = 0;
        lineRxData = 8'ha3;
        repeat (3) @(posedge sys_clk);
        #1 exp = {msg, crc[15:8], crc[7:0]};
        `CHK("rx ends", 1, nEnd)
        `CHK("crc error", m == 3, endErr)
        `CHK("crc good", m == 2, endGood)
      end
      `CHK("count", exp.size(), m < 2 ? host.got.size() : got.size())
      foreach (exp[i]) `CHK("byte", exp[i], m < 2 ? host.got[i] : got[i])
      $display("test %0d mode %0d done", k, m);
    end
    conclude();
  end
endmodule : emf_framer_bench
